// [hdl/stc_cfg.svh]
// Register offsets, field positions and reset values of the transfer controller
`ifndef STC_CFG_SVH
`define STC_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define STC_OFS_CTRL      8'h00
`define STC_OFS_DIV       8'h04
`define STC_OFS_RXDATA    8'h10
`define STC_OFS_TXDATA    8'h20
`define STC_OFS_CTRL2     8'h3c

// ****************************************
// Transfer control fields
// ****************************************
`define STC_B_TXFULL      27
`define STC_B_TXEMPTY     26
`define STC_B_FIFO        21
`define STC_B_SLAVE       18
`define STC_B_DONE        16
`define STC_F_SP_HI       15
`define STC_F_SP_LO       12
`define STC_B_CPOL        11
`define STC_B_LSB         10
`define STC_F_LEN_HI      7
`define STC_F_LEN_LO      3
`define STC_B_TXNEG       2
`define STC_B_RXNEG       1
`define STC_B_GO          0
`define STC_B_BYPASS      31
`define STC_F_DIV_HI      7
`define STC_F_DIV_LO      0

// ****************************************
// Reset values, full word length and FIFO depth
// ****************************************
`define STC_SP_RST        4'h3
`define STC_DIV_RST       8'h00
`define STC_LEN_FULL      6'h20
`define STC_TXF_DEPTH     3'h4

`endif

// [hdl/stc_pkg.sv]
// Types shared by the transfer controller files
package stc_pkg;

   // ****************************************
   // Register port request
   // ****************************************
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } stc_bus_req_s;

   // ****************************************
   // Engine states
   // ****************************************
   typedef enum logic [1:0] {
      STC_IDLE  = 2'b00,
      STC_SHIFT = 2'b01,
      STC_GAP   = 2'b10
   } stc_state_e;

endpackage : stc_pkg

// [hdl/stc_clkdiv.sv]
// Serial clock divider producing half-period ticks
`timescale 1ns/1ps
module stc_clkdiv (
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_en,
   input  wire logic [7:0] i_div,
   input  wire logic       i_bypass,
   output logic            o_tick
);
   typedef struct packed {
      logic [9:0] cnt;
      logic       tick;
   } stc_div_s;

   stc_div_s   s_q;
   stc_div_s   s_d;
   logic [9:0] per;
   logic [9:0] half;

   // ****************************************
   // Period in source clocks, never below two
   // ****************************************
   always_comb begin
      per = i_bypass ? {2'b00, i_div} + 10'd1 : {1'b0, i_div, 1'b0} + 10'd2; // [RL16] [RL17]
      if (per < 10'd2) begin
         per = 10'd2;
      end
      half = {1'b0, per[9:1]};
      s_d  = s_q;
      s_d.tick = 1'b0;
      if (!i_en) begin
         s_d.cnt = 10'd0;
      end else begin
         s_d.cnt  = (s_q.cnt == per - 10'd1) ? 10'd0 : s_q.cnt + 10'd1;
         s_d.tick = (s_q.cnt == half - 10'd1) || (s_q.cnt == per - 10'd1);
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_tick = s_q.tick;

   property p_div_spacing;
      @(posedge i_clk) disable iff (!i_rst_n)
      (i_en && !i_bypass && i_div == 8'h01 && $past(i_en) && o_tick) |=> !o_tick;
   endproperty
   a_div_spacing: assert property (p_div_spacing) // [RL16]
      else $error("divider tick spacing too short");

endmodule : stc_clkdiv

// [hdl/stc_core.sv]
// Serial transfer controller: control fields, divider, go/busy and shift engine
`timescale 1ns/1ps
`include "stc_cfg.svh"

// Functional notes
// RL1: master gap is suspend value plus half
// RL2: gap spans last edge to next first
// RL3: suspend field resets to three
// RL4: idle serial clock level follows polarity
// RL5: bit order bit picks MSB or LSB
// RL6: length codes 8..31, zero means 32
// RL7: software never programs lengths below eight
// RL8: drive edge bit picks output change edge
// RL9: sample edge bit picks input latch edge
// RL10: FIFO mode makes go bit hardware-only
// RL11: go holds during transfer, clears at end
// RL12: writing go zero stops active transfer
// RL13: go one starts master, readies slave
// RL14: software configures fully before setting go
// RL15: slave go survives select release unclocked
// RL16: normal divide is twice divider plus one
// RL17: bypass divide is divider plus one; the code divides by two at divider zero
// RL18: divider sets master serial clock rate
// RL19: FIFO master go follows queued data
// RL20: role bit zero master, one slave
// RL21: word done flag set, write-one clears
// RL22: gap timed by divider ticks, clock idle
module stc_core (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   input  wire stc_pkg::stc_bus_req_s i_bus,
   output logic [31:0]                o_rdata,
   input  wire logic                  i_sclk,
   input  wire logic                  i_ss_n,
   input  wire logic                  i_sdi,
   output logic                       o_sclk,
   output logic                       o_sclk_oe,
   output logic                       o_sdo,
   output logic                       o_sdo_oe
);
   import stc_pkg::*;

   typedef struct packed {
      stc_state_e       st;
      logic [3:0]       sp;
      logic             cpol;
      logic             lsb;
      logic [4:0]       len;
      logic             txneg;
      logic             rxneg;
      logic             go;
      logic             fifo;
      logic             slave;
      logic             done;
      logic [7:0]       div;
      logic             bypass;
      logic [3:0][31:0] txf;
      logic [1:0]       wp;
      logic [1:0]       rp;
      logic [2:0]       cnt;
      logic [31:0]      shr;
      logic [31:0]      rx;
      logic [31:0]      rdata;
      logic [5:0]       ecnt;
      logic [5:0]       dk;
      logic [5:0]       rk;
      logic [4:0]       gap;
      logic             sclk;
      logic             sclk_oe;
      logic             sdo;
      logic             sdo_oe;
      logic             sclk_prev;
   } stc_core_s;

   stc_core_s  s_q;
   stc_core_s  s_d;
   logic       tick;
   logic [5:0] nb;
   logic [5:0] last;
   logic [6:0] last7;
   logic       edge_ok;
   logic       rise;
   logic       word_end;
   logic       do_load;
   logic       wr_ctrl;
   logic [4:0] ri;

   // ****************************************
   // Bit selection by order and length
   // ****************************************
   function automatic logic [4:0] bit_idx(input logic lsb, input logic [5:0] n,
                                          input logic [5:0] k);
      logic [5:0] t;
      t = lsb ? k : n - 6'd1 - k; // [RL5]
      return t[4:0];
   endfunction : bit_idx

   // ****************************************
   // Divider
   // ****************************************
   stc_clkdiv u_div (
      .i_clk    (i_clk),
      .i_rst_n  (i_rst_n),
      .i_en     (!s_q.slave && s_q.st != STC_IDLE), // [RL18]
      .i_div    (s_q.div),
      .i_bypass (s_q.bypass),
      .o_tick   (tick)
   );

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      s_d      = s_q;
      do_load  = 1'b0;
      word_end = 1'b0;
      ri       = 5'd0;
      wr_ctrl  = i_bus.wr && i_bus.addr == `STC_OFS_CTRL;
      nb       = (s_q.len == 5'd0) ? `STC_LEN_FULL : {1'b0, s_q.len}; // [RL6]
      last7    = {nb, 1'b0} - 7'd1;
      last     = last7[5:0];
      s_d.sclk_prev = i_sclk;
      if (s_q.slave) begin // [RL20]
         edge_ok = s_q.st == STC_SHIFT && !i_ss_n && i_sclk != s_q.sclk_prev; // [RL15]
         rise    = i_sclk;
      end else begin
         edge_ok = s_q.st == STC_SHIFT && tick;
         rise    = ~s_q.sclk;
      end
      s_d.sclk_oe = !s_q.slave;
      s_d.sdo_oe  = !s_q.slave || (!i_ss_n && s_q.st != STC_IDLE);

      unique case (s_q.st)
         STC_IDLE: begin
            s_d.sclk = s_q.cpol; // [RL4]
            if (s_q.fifo && s_q.cnt != 3'd0) begin
               do_load = 1'b1; // [RL19]
            end
         end
         STC_SHIFT: begin
            if (edge_ok) begin
               s_d.ecnt = s_q.ecnt + 6'd1;
               if (!s_q.slave) begin
                  s_d.sclk = ~s_q.sclk;
               end
               if (rise != s_q.rxneg) begin // [RL9]
                  ri = bit_idx(s_q.lsb, nb, s_q.rk);
                  s_d.shr[ri] = i_sdi;
                  s_d.rk = s_q.rk + 6'd1;
               end
               if (rise != s_q.txneg && s_q.ecnt != 6'd0 && s_q.dk < nb - 6'd1) begin // [RL8]
                  s_d.dk  = s_q.dk + 6'd1;
                  s_d.sdo = s_q.txf[s_q.rp][bit_idx(s_q.lsb, nb, s_q.dk + 6'd1)];
               end
               if (s_q.ecnt == last) begin
                  word_end = 1'b1;
                  s_d.rx   = s_d.shr;
                  s_d.done = 1'b1; // [RL21]
                  if (s_q.fifo) begin
                     s_d.rp  = s_q.rp + 2'd1;
                     s_d.cnt = s_q.cnt - 3'd1;
                     if (s_d.cnt == 3'd0) begin
                        s_d.st = STC_IDLE;
                     end else if (s_q.slave || s_q.sp == 4'h0) begin
                        do_load = 1'b1; // [RL1]
                     end else begin
                        s_d.st  = STC_GAP; // [RL2]
                        s_d.gap = 5'd1;
                     end
                  end else begin
                     s_d.go = 1'b0; // [RL11]
                     s_d.st = STC_IDLE;
                  end
               end
            end
         end
         STC_GAP: begin
            s_d.sclk = s_q.cpol; // [RL22]
            if (tick) begin
               if (s_q.gap == {s_q.sp, 1'b0}) begin
                  do_load = 1'b1; // [RL1]
               end else begin
                  s_d.gap = s_q.gap + 5'd1; // [RL22]
               end
            end
         end
         default: begin
            s_d.st = STC_IDLE;
         end
      endcase

      // ****************************************
      // Register writes
      // ****************************************
      if (wr_ctrl) begin
         s_d.fifo  = i_bus.wdata[`STC_B_FIFO];
         s_d.slave = i_bus.wdata[`STC_B_SLAVE];
         s_d.sp    = i_bus.wdata[`STC_F_SP_HI:`STC_F_SP_LO];
         s_d.cpol  = i_bus.wdata[`STC_B_CPOL];
         s_d.lsb   = i_bus.wdata[`STC_B_LSB];
         s_d.len   = i_bus.wdata[`STC_F_LEN_HI:`STC_F_LEN_LO];
         s_d.txneg = i_bus.wdata[`STC_B_TXNEG];
         s_d.rxneg = i_bus.wdata[`STC_B_RXNEG];
         if (i_bus.wdata[`STC_B_DONE] && !word_end) begin
            s_d.done = 1'b0; // [RL21]
         end
         if (!s_q.fifo) begin // [RL10]
            if (i_bus.wdata[`STC_B_GO] && s_q.st == STC_IDLE) begin
               s_d.go  = 1'b1; // [RL13]
               do_load = 1'b1;
            end else if (!i_bus.wdata[`STC_B_GO] && s_q.st != STC_IDLE && !word_end) begin
               s_d.go   = 1'b0; // [RL12]
               s_d.st   = STC_IDLE;
               s_d.sclk = i_bus.wdata[`STC_B_CPOL];
               do_load  = 1'b0;
            end
         end
      end
      if (i_bus.wr && i_bus.addr == `STC_OFS_DIV) begin
         s_d.div = i_bus.wdata[`STC_F_DIV_HI:`STC_F_DIV_LO]; // [RL18]
      end
      if (i_bus.wr && i_bus.addr == `STC_OFS_CTRL2) begin
         s_d.bypass = i_bus.wdata[`STC_B_BYPASS]; // [RL17]
      end
      if (i_bus.wr && i_bus.addr == `STC_OFS_TXDATA) begin
         if (!s_q.fifo) begin
            s_d.txf[s_q.rp] = i_bus.wdata;
         end else if (s_d.cnt != `STC_TXF_DEPTH) begin
            s_d.txf[s_q.wp] = i_bus.wdata; // [RL19]
            s_d.wp  = s_q.wp + 2'd1;
            s_d.cnt = s_d.cnt + 3'd1;
         end
      end

      // ****************************************
      // Word load and hardware go
      // ****************************************
      if (do_load) begin
         s_d.st   = STC_SHIFT;
         s_d.ecnt = 6'd0;
         s_d.dk   = 6'd0;
         s_d.rk   = 6'd0;
         s_d.shr  = 32'h0;
         s_d.sdo  = s_d.txf[s_d.rp][bit_idx(s_d.lsb, nb, 6'd0)]; // [RL5]
      end
      if (s_d.fifo) begin
         s_d.go = s_d.st != STC_IDLE; // [RL10] [RL19]
      end

      // ****************************************
      // Read data, valid in the following cycle
      // ****************************************
      s_d.rdata = 32'h0;
      if (i_bus.rd) begin
         unique case (i_bus.addr)
            `STC_OFS_CTRL: begin
               s_d.rdata[`STC_B_TXFULL]  = s_q.cnt == `STC_TXF_DEPTH;
               s_d.rdata[`STC_B_TXEMPTY] = s_q.cnt == 3'd0;
               s_d.rdata[`STC_B_FIFO]    = s_q.fifo;
               s_d.rdata[`STC_B_SLAVE]   = s_q.slave;
               s_d.rdata[`STC_B_DONE]    = s_q.done;
               s_d.rdata[`STC_F_SP_HI:`STC_F_SP_LO]   = s_q.sp;
               s_d.rdata[`STC_B_CPOL]    = s_q.cpol;
               s_d.rdata[`STC_B_LSB]     = s_q.lsb;
               s_d.rdata[`STC_F_LEN_HI:`STC_F_LEN_LO] = s_q.len;
               s_d.rdata[`STC_B_TXNEG]   = s_q.txneg;
               s_d.rdata[`STC_B_RXNEG]   = s_q.rxneg;
               s_d.rdata[`STC_B_GO]      = s_q.go;
            end
            `STC_OFS_DIV: begin
               s_d.rdata[`STC_F_DIV_HI:`STC_F_DIV_LO] = s_q.div;
            end
            `STC_OFS_CTRL2: begin
               s_d.rdata[`STC_B_BYPASS] = s_q.bypass;
            end
            `STC_OFS_RXDATA: begin
               s_d.rdata = s_q.rx;
            end
            default: begin
               s_d.rdata = 32'h0;
            end
         endcase
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q         <= '0;
         s_q.sp      <= `STC_SP_RST; // [RL3]
         s_q.div     <= `STC_DIV_RST;
         s_q.sclk_oe <= 1'b1;
         s_q.sdo_oe  <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_rdata   = s_q.rdata;
   assign o_sclk    = s_q.sclk;
   assign o_sclk_oe = s_q.sclk_oe;
   assign o_sdo     = s_q.sdo;
   assign o_sdo_oe  = s_q.sdo_oe;

   // ****************************************
   // Checks
   // ****************************************
   property p_idle_level;
      @(posedge i_clk) disable iff (!i_rst_n)
      (!s_q.slave && s_q.st == STC_IDLE && $past(s_q.st) == STC_IDLE
       && $stable(s_q.cpol)) |-> o_sclk == s_q.cpol;
   endproperty
   a_idle_level: assert property (p_idle_level) // [RL4]
      else $error("serial clock not at idle level");

   property p_gap_bound;
      @(posedge i_clk) disable iff (!i_rst_n)
      s_q.st == STC_GAP |-> s_q.gap >= 5'd1 && s_q.gap <= {s_q.sp, 1'b0};
   endproperty
   a_gap_bound: assert property (p_gap_bound) // [RL1]
      else $error("suspend counter out of range");

   property p_gap_clock;
      @(posedge i_clk) disable iff (!i_rst_n)
      (s_q.st == STC_GAP && $past(s_q.st) == STC_GAP) |-> o_sclk == s_q.cpol;
   endproperty
   a_gap_clock: assert property (p_gap_clock) // [RL22]
      else $error("serial clock moved during suspend gap");

   property p_fifo_go;
      @(posedge i_clk) disable iff (!i_rst_n)
      (s_q.fifo && s_q.st == STC_IDLE && s_q.cnt == 3'd0 && wr_ctrl
       && i_bus.wdata[`STC_B_FIFO] && i_bus.wdata[`STC_B_GO]) |=> !s_q.go;
   endproperty
   a_fifo_go: assert property (p_fifo_go) // [RL10]
      else $error("software set go in fifo mode");

   property p_stop;
      @(posedge i_clk) disable iff (!i_rst_n)
      (!s_q.fifo && s_q.st == STC_SHIFT && !word_end && wr_ctrl
       && !i_bus.wdata[`STC_B_GO]) |=> s_q.st == STC_IDLE && !s_q.go;
   endproperty
   a_stop: assert property (p_stop) // [RL12]
      else $error("go zero did not stop transfer");

   property p_start;
      @(posedge i_clk) disable iff (!i_rst_n)
      (!s_q.fifo && s_q.st == STC_IDLE && wr_ctrl && i_bus.wdata[`STC_B_GO])
      |=> s_q.st == STC_SHIFT && s_q.go && s_q.ecnt == 6'd0;
   endproperty
   a_start: assert property (p_start) // [RL13]
      else $error("go one did not start transfer");

   property p_done;
      @(posedge i_clk) disable iff (!i_rst_n)
      word_end |=> s_q.done && (s_q.fifo || (!s_q.go && s_q.st == STC_IDLE));
   endproperty
   a_done: assert property (p_done) // [RL21]
      else $error("word end did not set done");

   property p_word_edges;
      @(posedge i_clk) disable iff (!i_rst_n)
      word_end |-> {1'b0, s_q.ecnt} + 7'd1 == ((s_q.len == 5'd0) ? 7'h40 : {1'b0, s_q.len, 1'b0});
   endproperty
   a_word_edges: assert property (p_word_edges) // [RL6]
      else $error("word edge count wrong");

   property p_slave_hold;
      @(posedge i_clk) disable iff (!i_rst_n)
      (s_q.slave && !s_q.fifo && s_q.go && $rose(i_ss_n) && $stable(i_sclk)
       && !wr_ctrl) |=> s_q.go;
   endproperty
   a_slave_hold: assert property (p_slave_hold) // [RL15]
      else $error("slave go cleared on select release");

endmodule : stc_core

// [test/stc_peer.sv]
// Serial peer model: answers the master with a fixed word and records what it receives
`timescale 1ns/1ps
module stc_peer (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_clr,
   input  wire logic        i_sclk,
   input  wire logic        i_sdo,
   input  wire logic        i_cpol,
   input  wire logic        i_lsb,
   input  wire logic        i_txneg,
   input  wire logic        i_rxneg,
   input  wire logic [5:0]  i_len,
   input  wire logic [31:0] i_tx,
   input  wire logic        i_sel,
   output logic             o_sdi,
   output logic             o_sclk,
   output logic             o_ss_n,
   output logic [31:0]      o_cap
);
   logic       prev_q;
   logic [5:0] k_q;
   logic       rise;
   logic       fall;
   // ****************************************
   // Edge tracking and data lines
   // ****************************************
   assign rise   = i_sclk & ~prev_q;
   assign fall   = ~i_sclk & prev_q;
   // Bit index moves only after the device has taken a bit, so each bit is stable when sampled
   assign o_sdi  = i_tx[i_lsb ? k_q[4:0] : 5'(i_len - 6'h01 - k_q)];
   // As master in slave tests the clock stands still at its idle level
   assign o_sclk = i_cpol;
   assign o_ss_n = ~i_sel;
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         prev_q <= 1'b0;
         k_q    <= 6'h00;
         o_cap  <= 32'h00000000;
      end else begin
         prev_q <= i_sclk;
         if (i_clr) begin
            k_q <= 6'h00;
         end else if (i_rxneg ? fall : rise) begin
            k_q <= (k_q == i_len - 6'h01) ? 6'h00 : k_q + 6'h01;
         end
         if (i_txneg ? rise : fall) begin
            o_cap <= {o_cap[30:0], i_sdo};
         end
      end
   end
endmodule : stc_peer

// [test/tb_top.sv]
// Self-checking bench for the serial transfer controller
`timescale 1ns/1ps
`include "stc_cfg.svh"
module tb_top;
   import stc_pkg::*;
   logic         i_clk;
   logic         i_rst_n;
   stc_bus_req_s bus;
   logic [31:0]  rdata, cap, ptx, v;
   logic         sclk, sclk_oe, sdo, sdo_oe, sdi, m_sclk, ss_n, sclk_p;
   logic         cpol, lsb, txn, rxn, sel, pclr;
   logic [5:0]   plen;
   int           fail_count, comparisons, edges, gmin, gmax, cnt, n, half;
   logic [31:0]  t_ptx [4] = '{32'h000000a5, 32'h00001c3d, 32'h8d3c5a69, 32'h4b2e9167};
   int           t_code [4] = '{8, 13, 0, 31};
   int           t_div [4] = '{2, 3, 0, 0};
   logic [3:0]   t_pol = 4'b1010, t_lsb = 4'b0110, t_txn = 4'b1001, t_byp = 4'b0110;

   stc_core i_stc_core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata),
      .i_sclk(m_sclk), .i_ss_n(ss_n), .i_sdi(sdi), .o_sclk(sclk), .o_sclk_oe(sclk_oe),
      .o_sdo(sdo), .o_sdo_oe(sdo_oe));
   stc_peer i_stc_peer (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_clr(pclr), .i_sclk(sclk),
      .i_sdo(sdo), .i_cpol(cpol), .i_lsb(lsb), .i_txneg(txn), .i_rxneg(rxn), .i_len(plen),
      .i_tx(ptx), .i_sel(sel), .o_sdi(sdi), .o_sclk(m_sclk), .o_ss_n(ss_n), .o_cap(cap));

   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   // ****************************************
   // Serial clock edge monitor
   // ****************************************
   always @(posedge i_clk) begin
      sclk_p <= sclk;
      if (sclk !== sclk_p) begin
         edges++;
         if (edges > 1 && cnt + 1 < gmin) gmin = cnt + 1;
         if (edges > 1 && cnt + 1 > gmax) gmax = cnt + 1;
         cnt = 0;
      end else begin
         cnt++;
      end
   end
   // ****************************************
   // Bus access and compare tasks
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      bus.addr  <= a;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge i_clk);
      bus.wr    <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clk);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge i_clk);
      bus.rd   <= 1'b0;
      #1;
      d = rdata;
   endtask : rd
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk32
   task automatic chkn(input int got, input int exp);
      comparisons++;
      if (got != exp) begin
         fail_count++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chkn
   task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk32(d & m, e);
   endtask : rdchk
   task automatic wait_go0();
      int i;
      i = 0;
      v = 32'h00000001;
      while (v[0] !== 1'b0 && i < 400) begin
         rd(`STC_OFS_CTRL, v);
         i++;
      end
      chkn(int'(i < 400), 1);
   endtask : wait_go0
   task automatic restart();
      pclr <= 1'b1;
      @(posedge i_clk);
      pclr <= 1'b0;
      edges = 0;
      gmin  = 9999;
      gmax  = 0;
   endtask : restart
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_sim
   function automatic logic [31:0] msk(input logic [31:0] w, input int k);
      return (k == 32) ? w : w & ((32'h1 << k) - 32'h1);
   endfunction : msk
   function automatic logic [31:0] wire_word(input logic [31:0] w, input int k, input logic l);
      logic [31:0] r;
      r = 32'h0;
      for (int i = 0; i < k; i++) r[k-1-i] = l ? w[i] : w[k-1-i];
      return r;
   endfunction : wire_word

   initial begin
      repeat (40000) @(posedge i_clk);
      fail_count++;
      $display("watchdog expired");
      end_sim();
   end
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      logic [31:0] c;
      bus <= '0; i_rst_n <= 1'b0; pclr <= 1'b0; sel <= 1'b0;
      cpol = 1'b0; lsb = 1'b0; txn = 1'b1; rxn = 1'b0; plen = 6'h08; ptx = 32'h0;
      fail_count = 0; comparisons = 0; edges = 0; cnt = 0; gmin = 9999; gmax = 0;
      repeat (8) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rdchk(`STC_OFS_CTRL, 32'hf3ffffff, 32'h00003000);
      rdchk(`STC_OFS_DIV, 32'hffffffff, 32'h00000000);
      rdchk(`STC_OFS_CTRL2, 32'hffffffff, 32'h00000000);
      rdchk(8'h08, 32'hffffffff, 32'h00000000);
      wr(`STC_OFS_DIV, 32'hffffffff);
      rdchk(`STC_OFS_DIV, 32'hffffffff, 32'h000000ff);
      $display("register reset test done");
      for (int i = 0; i < 4; i++) begin
         n = (t_code[i] == 0) ? 32 : t_code[i];
         half = t_byp[i] ? ((t_div[i] == 0) ? 1 : (t_div[i] + 1) / 2) : t_div[i] + 1;
         cpol = t_pol[i]; lsb = t_lsb[i]; txn = t_txn[i]; rxn = ~t_txn[i];
         plen = 6'(n); ptx = t_ptx[i];
         c = 32'h00003000 | {20'h0, cpol, lsb, 2'b00, 5'(t_code[i]), txn, rxn, 1'b0};
         wr(`STC_OFS_CTRL2, {t_byp[i], 31'h0});
         wr(`STC_OFS_DIV, 32'(t_div[i]));
         wr(`STC_OFS_TXDATA, ~t_ptx[i]);
         wr(`STC_OFS_CTRL, c);
         repeat (2) @(posedge i_clk);
         chk32({31'h0, sclk}, {31'h0, cpol});
         restart();
         wr(`STC_OFS_CTRL, c | 32'h1);
         rdchk(`STC_OFS_CTRL, 32'h00000001, 32'h00000001);
         wait_go0();
         chkn(edges, 2 * n);
         chkn(gmin, half);
         chkn(gmax, half);
         chk32({31'h0, sclk}, {31'h0, cpol});
         rdchk(`STC_OFS_RXDATA, 32'hffffffff, msk(ptx, n));
         chk32(msk(cap, n), wire_word(~ptx, n, lsb));
         rdchk(`STC_OFS_CTRL, 32'h00010001, 32'h00010000);
         wr(`STC_OFS_CTRL, c | 32'h00010000);
         rdchk(`STC_OFS_CTRL, 32'h00010000, 32'h00000000);
         $display("transfer case %0d done", i);
      end
      cpol = 1'b0; lsb = 1'b0; txn = 1'b1; rxn = 1'b0; plen = 6'h08; ptx = 32'h0000005c;
      wr(`STC_OFS_CTRL2, 32'h0);
      wr(`STC_OFS_DIV, 32'h1);
      for (int s = 3; s >= 0; s -= 3) begin
         c = 32'h00200044 | (32'(s) << 12);
         wr(`STC_OFS_CTRL, c);
         repeat (2) @(posedge i_clk);
         restart();
         wr(`STC_OFS_TXDATA, 32'h000000c3);
         wr(`STC_OFS_TXDATA, 32'h0000003c);
         rdchk(`STC_OFS_CTRL, 32'h00000001, 32'h00000001);
         wr(`STC_OFS_CTRL, c);
         rdchk(`STC_OFS_CTRL, 32'h00000001, 32'h00000001);
         wait_go0();
         chkn(edges, 32);
         chkn(gmax, (2 * s + 1) * 2);
         chkn(gmin, 2);
         rdchk(`STC_OFS_RXDATA, 32'hffffffff, 32'h0000005c);
         wr(`STC_OFS_CTRL, c | 32'h1);
         rdchk(`STC_OFS_CTRL, 32'h00000001, 32'h00000000);
         $display("suspend gap %0d test done", s);
      end
      c = 32'h00003004;
      wr(`STC_OFS_DIV, 32'h9);
      wr(`STC_OFS_CTRL, c);
      restart();
      wr(`STC_OFS_CTRL, c | 32'h1);
      repeat (60) @(posedge i_clk);
      wr(`STC_OFS_CTRL, c);
      rdchk(`STC_OFS_CTRL, 32'h00000001, 32'h00000000);
      repeat (40) @(posedge i_clk);
      chkn(int'(edges < 64), 1);
      chk32({31'h0, sclk}, 32'h0);
      $display("stop test done");
      wr(`STC_OFS_CTRL, 32'h00043001);
      repeat (2) @(posedge i_clk);
      chk32({31'h0, sclk_oe}, 32'h0);
      sel <= 1'b1;
      repeat (10) @(posedge i_clk);
      sel <= 1'b0;
      repeat (10) @(posedge i_clk);
      rdchk(`STC_OFS_CTRL, 32'h00040001, 32'h00040001);
      wr(`STC_OFS_CTRL, 32'h00043000);
      rdchk(`STC_OFS_CTRL, 32'h00000001, 32'h00000000);
      wr(`STC_OFS_CTRL, 32'h00003000);
      repeat (2) @(posedge i_clk);
      chk32({30'h0, sclk_oe, sdo_oe}, 32'h3);
      $display("slave test done");
      end_sim();
   end
endmodule : tb_top
